// ===== shared/iocm_pkg.sv
// Purpose: Shared constants and types for the I/O channel mode sequencer.
// Assumes: Eight channels, currents in microamps, percent in 0.01 % steps.
// Notes: Timing figures are kept in their own unit and converted here.
package iocm_pkg;
	localparam int NCH = 8; // Channels per module
	localparam int CLK_NS = 40; // Clock period, ns
	localparam int MS_NS = 1000000; // One millisecond, ns
	localparam int MS_CYC = MS_NS / CLK_NS; // Cycles per millisecond
	localparam int FIELD_REFRESH_MS = 4000; // Longest field data refresh
	localparam int POLL_MS = 1000; // Field poll interval, inside refresh
	localparam int CMD_TIMEOUT_MS = 100; // Commanded value watchdog
	localparam logic [15:0] LO_SIG_RST = 16'h0fa0; // 4 mA at 0 %
	localparam logic [15:0] HI_SIG_RST = 16'h4e20; // 20 mA at 100 %
	localparam logic [15:0] I_MAX = 16'h5dc0; // 24 mA clamp
	localparam logic signed [31:0] ENG_FULL = 32'sh0000_2710; // 100.00 %
	localparam logic [7:0] CMD_READ_ID = 8'h00; // Field read unique id
	localparam logic [7:0] CMD_READ_DYN = 8'h03; // Field read variables
	localparam logic [15:0] AGE_MAX = 16'hffff; // Saturating age
	// Configuration item selects
	localparam logic [2:0] CFG_SD_SEL = 3'h0;
	localparam logic [2:0] CFG_SD_VAL = 3'h1;
	localparam logic [2:0] CFG_PG_SEL = 3'h2;
	localparam logic [2:0] CFG_PG_VAL = 3'h3;
	localparam logic [2:0] CFG_LO_SIG = 3'h4;
	localparam logic [2:0] CFG_HI_SIG = 3'h5;
	localparam logic [2:0] CFG_FLD_EN = 3'h6;
	typedef enum logic [5:0] {
		M_OFFLINE = 6'h01,
		M_SHUTDOWN = 6'h02,
		M_READY = 6'h04,
		M_RECOVER = 6'h08,
		M_RUN = 6'h10,
		M_PROGRAM = 6'h20
	} iocm_mode_t;
	typedef enum logic [1:0] {
		SEL_OFF = 2'h0,
		SEL_HOLD = 2'h1,
		SEL_VALUE = 2'h2
	} iocm_sel_t;
	typedef enum logic [1:0] {
		LED_OFF = 2'h0,
		LED_GREEN = 2'h1,
		LED_RED = 2'h2
	} iocm_led_t;
	typedef logic [NCH-1:0][15:0] iocm_w16_t;
	typedef logic [NCH-1:0][7:0] iocm_w8_t;
	typedef iocm_led_t [NCH-1:0] iocm_leds_t;
	typedef iocm_sel_t [NCH-1:0] iocm_sels_t;
endpackage

// ===== shared/iocm_link_if.sv
// Purpose: Link between owner controller end and I/O module end.
// Assumes: Both ends on the same clock; no synchronisers needed here.
// Notes: Plain signals, one modport per end.
`timescale 1ns/1ps
interface iocm_link_if;
	import iocm_pkg::*;
	logic comm; // Communication with processors up
	logic app_run; // Application running
	logic inhibit; // Module inhibited
	logic cmd_valid; // Commanded value pulse
	logic [2:0] cmd_ch;
	logic signed [15:0] cmd_pct; // 0.01 % units
	logic cfg_valid; // Configuration write pulse
	logic [2:0] cfg_ch;
	logic [2:0] cfg_sel;
	logic [15:0] cfg_data;
	logic rd_req; // Channel report request pulse
	logic [2:0] rd_ch;
	iocm_mode_t mode; // Module mode
	logic rd_ack; // Report answer pulse
	logic signed [31:0] rd_eng; // Measured value, 0.01 % units
	logic [15:0] rd_fdata; // Field primary variable
	logic [7:0] rd_fstat; // Field device status
	logic rd_ferr; // Field communication error
	logic [15:0] rd_age; // ms since last field update
	modport owner(output comm, app_run, inhibit, cmd_valid, cmd_ch,
		cmd_pct, cfg_valid, cfg_ch, cfg_sel, cfg_data, rd_req, rd_ch,
		input mode, rd_ack, rd_eng, rd_fdata, rd_fstat, rd_ferr, rd_age);
	modport dev(input comm, app_run, inhibit, cmd_valid, cmd_ch,
		cmd_pct, cfg_valid, cfg_ch, cfg_sel, cfg_data, rd_req, rd_ch,
		output mode, rd_ack, rd_eng, rd_fdata, rd_fstat, rd_ferr, rd_age);
endinterface // iocm_link_if

// ===== rtl/iocm_dev.sv
// Purpose: I/O module end: mode sequencing, scaling, field data polling.
// Assumes: Lock, power fault and partner pins are asynchronous; field
//          responses and measurements come from logic on CLK_IN.
// Notes: Functional notes below list the behaviour this end keeps.
`timescale 1ns/1ps
module iocm_dev #(
	parameter int MS_CYCLES = iocm_pkg::MS_CYC, // Shorten in simulation
	parameter int POLL_PERIOD_MS = iocm_pkg::POLL_MS,
	parameter int CMD_TIMEOUT = iocm_pkg::CMD_TIMEOUT_MS
) (
	input wire logic CLK_IN,
	input wire logic RST_IN,
	iocm_link_if.dev lnk,
	input wire logic LOCK_IN,
	input wire logic POWER_FAULT_IN,
	input wire logic PARTNER_RUN_IN,
	input wire iocm_pkg::iocm_w16_t MEAS_IN,
	input wire logic FIELD_RSP_VALID_IN,
	input wire logic [2:0] FIELD_RSP_CH_IN,
	input wire logic [7:0] FIELD_RSP_CMD_IN,
	input wire logic [15:0] FIELD_RSP_DATA_IN,
	input wire logic [7:0] FIELD_RSP_STAT_IN,
	input wire logic FIELD_RSP_ERR_IN,
	output iocm_pkg::iocm_w16_t CH_CURRENT_OUT,
	output logic [7:0] CH_ON_OUT,
	output logic [7:0] FIELD_REQ_OUT,
	output iocm_pkg::iocm_w8_t FIELD_CMD_OUT,
	output iocm_pkg::iocm_led_t HEALTHY_LED_OUT,
	output iocm_pkg::iocm_led_t READY_LED_OUT,
	output iocm_pkg::iocm_led_t RUN_LED_OUT,
	output iocm_pkg::iocm_leds_t CH_LED_OUT,
	output iocm_pkg::iocm_mode_t MODE_OUT
);
	import iocm_pkg::*;

	// Whole module state in one record
	typedef struct packed {
		logic lock_m, lock_s, pf_m, pf_s, par_m, par_s; // Pin synchronisers
		iocm_mode_t mode;
		logic [15:0] ms_cnt; // Millisecond prescaler
		logic [15:0] poll_ms; // Field poll interval counter
		logic [15:0] cmd_age; // ms since last commanded value
		iocm_w16_t cmd; // Commanded percent per channel
		iocm_w16_t cur; // Driven current, uA
		logic [NCH-1:0] on; // Channel energised
		iocm_sels_t sd_sel, pg_sel; // Shutdown and program choices
		iocm_w16_t sd_val, pg_val, lo_sig, hi_sig;
		logic [NCH-1:0] fld_en, id_known, fld_err, freq;
		iocm_w16_t fld_data, age;
		iocm_w8_t fld_stat, fcmd;
		iocm_led_t healthy, ready, run;
		iocm_leds_t ch_led;
		logic rd_ack, rd_ferr;
		logic signed [31:0] rd_eng;
		logic [15:0] rd_fdata, rd_age;
		logic [7:0] rd_fstat;
	} iocm_dev_st_t;

	iocm_dev_st_t r_reg; // Registered state
	iocm_dev_st_t r_next; // Next state
	iocm_w16_t scaled; // Commanded current per channel

	// Percent to current, linear over the configured span, then clamped
	function automatic logic [15:0] scale(input logic [15:0] pct,
		input logic [15:0] lo, input logic [15:0] hi);
		logic signed [31:0] v;
		v = (32'(signed'(pct)) * (signed'({16'h0000, hi}) -
			signed'({16'h0000, lo}))) / ENG_FULL +
			signed'({16'h0000, lo});
		if (v < 32'sh0000_0000) begin
			scale = 16'h0000;
		end else if (v > signed'({16'h0000, I_MAX})) begin
			scale = I_MAX;
		end else begin
			scale = v[15:0];
		end
	endfunction

	// Current to percent with no saturation, so faults stay visible
	function automatic logic signed [31:0] to_eng(input logic [15:0] m,
		input logic [15:0] lo, input logic [15:0] hi);
		logic signed [31:0] span;
		span = signed'({16'h0000, hi}) - signed'({16'h0000, lo});
		if (span == 32'sh0000_0000) begin
			to_eng = 32'sh0000_0000; // Degenerate span reads zero
		end else begin
			to_eng = ((signed'({16'h0000, m}) - signed'({16'h0000, lo})) *
				ENG_FULL) / span;
		end
	endfunction

	// Scaling is identical per channel
	for (genvar g = 0; g < NCH; g++) begin : g_scale
		assign scaled[g] = scale(r_reg.cmd[g], r_reg.lo_sig[g],
			r_reg.hi_sig[g]);
	end

	// Next-state logic for sequencing, channels, field polling, reports
	always_comb begin
		logic ms_tick;
		logic poll_tick;
		logic [2:0] c;
		logic [15:0] held;
		r_next = r_reg;
		ms_tick = (r_reg.ms_cnt == 16'(MS_CYCLES - 1));
		poll_tick = ms_tick && (r_reg.poll_ms == 16'(POLL_PERIOD_MS - 1));
		c = 3'h0;
		held = 16'h0000;
		// Only the second stage of each synchroniser is read
		r_next.lock_m = LOCK_IN;
		r_next.lock_s = r_reg.lock_m;
		r_next.pf_m = POWER_FAULT_IN;
		r_next.pf_s = r_reg.pf_m;
		r_next.par_m = PARTNER_RUN_IN;
		r_next.par_s = r_reg.par_m;
		r_next.ms_cnt = ms_tick ? 16'h0000 : r_reg.ms_cnt + 16'h0001;
		if (ms_tick) begin
			r_next.poll_ms = poll_tick ? 16'h0000 : r_reg.poll_ms + 16'h0001;
		end
		// Command watchdog runs only while in run
		if (lnk.comm && lnk.cmd_valid) begin
			r_next.cmd[lnk.cmd_ch] = lnk.cmd_pct;
			r_next.cmd_age = 16'h0000;
		end else if (r_reg.mode != M_RUN) begin
			r_next.cmd_age = 16'h0000;
		end else if (ms_tick && r_reg.cmd_age != AGE_MAX) begin
			r_next.cmd_age = r_reg.cmd_age + 16'h0001;
		end
		// Configuration writes; fixed currents clamped on entry
		if (lnk.comm && lnk.cfg_valid) begin
			c = lnk.cfg_ch;
			held = (lnk.cfg_data > I_MAX) ? I_MAX : lnk.cfg_data;
			case (lnk.cfg_sel)
				CFG_SD_SEL: r_next.sd_sel[c] = iocm_sel_t'(lnk.cfg_data[1:0]);
				CFG_SD_VAL: r_next.sd_val[c] = held;
				CFG_PG_SEL: r_next.pg_sel[c] = iocm_sel_t'(lnk.cfg_data[1:0]);
				CFG_PG_VAL: r_next.pg_val[c] = held;
				CFG_LO_SIG: r_next.lo_sig[c] = lnk.cfg_data;
				CFG_HI_SIG: r_next.hi_sig[c] = lnk.cfg_data;
				CFG_FLD_EN: r_next.fld_en[c] = lnk.cfg_data[0];
				default: r_next.fld_en = r_reg.fld_en; // Unused select ignored
			endcase
		end
		// Mode sequencing; lock and power fault override everything
		if (!r_reg.lock_s) begin
			r_next.mode = M_OFFLINE;
		end else if (r_reg.pf_s) begin
			r_next.mode = M_SHUTDOWN;
		end else begin
			case (r_reg.mode)
				M_OFFLINE: r_next.mode = M_SHUTDOWN;
				M_SHUTDOWN: begin
					if (lnk.comm) begin
						r_next.mode = lnk.app_run ? M_RECOVER : M_READY;
					end
				end
				M_READY: begin
					if (!lnk.comm) begin
						r_next.mode = M_SHUTDOWN;
					end else if (lnk.inhibit) begin
						r_next.mode = M_PROGRAM;
					end else if (lnk.app_run) begin
						r_next.mode = M_RUN;
					end
				end
				M_RECOVER: begin
					if (!lnk.comm) begin
						r_next.mode = M_SHUTDOWN;
					end else if (lnk.inhibit) begin
						r_next.mode = M_PROGRAM;
					end else if (lnk.cmd_valid) begin
						r_next.mode = M_RUN;
					end
				end
				M_RUN: begin
					if (!lnk.comm || r_reg.cmd_age >= 16'(CMD_TIMEOUT)) begin
						r_next.mode = M_SHUTDOWN;
					end else if (lnk.inhibit) begin
						r_next.mode = M_PROGRAM;
					end
				end
				M_PROGRAM: begin
					// Leaving program passes through shutdown again
					if (!lnk.comm || !lnk.inhibit) begin
						r_next.mode = M_SHUTDOWN;
					end
				end
				default: r_next.mode = M_OFFLINE;
			endcase
		end
		// Channel outputs follow the registered mode
		for (int i = 0; i < NCH; i++) begin
			case (r_reg.mode)
				M_RUN: begin
					r_next.on[i] = 1'b1;
					// Partner running shares the loop; alone we carry it all
					r_next.cur[i] = r_reg.par_s ? {1'b0, scaled[i][15:1]} :
						scaled[i];
				end
				M_SHUTDOWN, M_RECOVER, M_PROGRAM: begin
					if ((r_reg.mode == M_PROGRAM ? r_reg.pg_sel[i] :
						r_reg.sd_sel[i]) == SEL_VALUE) begin
						r_next.on[i] = 1'b1;
						r_next.cur[i] = (r_reg.mode == M_PROGRAM) ?
							r_reg.pg_val[i] : r_reg.sd_val[i];
					end else if ((r_reg.mode == M_PROGRAM ? r_reg.pg_sel[i] :
						r_reg.sd_sel[i]) != SEL_HOLD) begin
						r_next.on[i] = 1'b0;
						r_next.cur[i] = 16'h0000;
					end
				end
				default: begin
					r_next.on[i] = 1'b0;
					r_next.cur[i] = 16'h0000;
				end
			endcase
			r_next.ch_led[i] = (r_reg.mode == M_RUN) ? LED_GREEN : LED_OFF;
		end
		// Module indicators: healthy from power fault, ready and run per mode
		r_next.healthy = r_reg.pf_s ? LED_RED : LED_GREEN;
		case (r_reg.mode)
			M_OFFLINE: begin
				r_next.ready = LED_OFF;
				r_next.run = LED_RED;
			end
			M_SHUTDOWN: begin
				r_next.ready = LED_RED;
				r_next.run = LED_RED;
			end
			M_RUN: begin
				r_next.ready = LED_GREEN;
				r_next.run = LED_GREEN;
			end
			default: begin
				r_next.ready = LED_GREEN;
				r_next.run = LED_RED;
			end
		endcase
		// Field polling: every enabled channel at once, so count is free
		r_next.freq = '0;
		for (int i = 0; i < NCH; i++) begin
			if (!r_reg.fld_en[i]) begin
				r_next.id_known[i] = 1'b0;
			end else if (poll_tick) begin
				r_next.freq[i] = 1'b1;
				r_next.fcmd[i] = r_reg.id_known[i] ? CMD_READ_DYN :
					CMD_READ_ID;
			end
			if (ms_tick && r_reg.age[i] != AGE_MAX) begin
				r_next.age[i] = r_reg.age[i] + 16'h0001;
			end
		end
		if (FIELD_RSP_VALID_IN && r_reg.fld_en[FIELD_RSP_CH_IN]) begin
			c = FIELD_RSP_CH_IN;
			r_next.fld_err[c] = FIELD_RSP_ERR_IN;
			r_next.fld_stat[c] = FIELD_RSP_STAT_IN;
			if (!FIELD_RSP_ERR_IN && FIELD_RSP_CMD_IN == CMD_READ_ID) begin
				r_next.id_known[c] = 1'b1;
			end
			if (!FIELD_RSP_ERR_IN && FIELD_RSP_CMD_IN == CMD_READ_DYN) begin
				r_next.fld_data[c] = FIELD_RSP_DATA_IN;
				r_next.age[c] = 16'h0000;
			end
		end
		// Channel report, answered the cycle after the request
		r_next.rd_ack = lnk.comm && lnk.rd_req;
		if (lnk.comm && lnk.rd_req) begin
			c = lnk.rd_ch;
			r_next.rd_eng = to_eng(MEAS_IN[c], r_reg.lo_sig[c],
				r_reg.hi_sig[c]);
			r_next.rd_fdata = r_reg.fld_data[c];
			r_next.rd_fstat = r_reg.fld_stat[c];
			r_next.rd_ferr = r_reg.fld_err[c];
			r_next.rd_age = r_reg.age[c];
		end
	end

	// State register; defaults give offline, de-energise, 4..20 mA
	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			r_reg <= '0;
			r_reg.mode <= M_OFFLINE;
			r_reg.run <= LED_RED;
			r_reg.healthy <= LED_GREEN;
			r_reg.lo_sig <= {NCH{LO_SIG_RST}};
			r_reg.hi_sig <= {NCH{HI_SIG_RST}};
		end else begin
			r_reg <= r_next;
		end
	end

	// Outputs straight from the state register
	assign CH_CURRENT_OUT = r_reg.cur;
	assign CH_ON_OUT = r_reg.on;
	assign FIELD_REQ_OUT = r_reg.freq;
	assign FIELD_CMD_OUT = r_reg.fcmd;
	assign HEALTHY_LED_OUT = r_reg.healthy;
	assign READY_LED_OUT = r_reg.ready;
	assign RUN_LED_OUT = r_reg.run;
	assign CH_LED_OUT = r_reg.ch_led;
	assign MODE_OUT = r_reg.mode;
	assign lnk.mode = r_reg.mode;
	assign lnk.rd_ack = r_reg.rd_ack;
	assign lnk.rd_eng = r_reg.rd_eng;
	assign lnk.rd_fdata = r_reg.rd_fdata;
	assign lnk.rd_fstat = r_reg.rd_fstat;
	assign lnk.rd_ferr = r_reg.rd_ferr;
	assign lnk.rd_age = r_reg.rd_age;
endmodule // iocm_dev

// ===== rtl/iocm_owner.sv
// Purpose: Owner controller end: connection, inhibit and traffic gating.
// Assumes: User side and link run on CLK_IN; no pin inputs here.
// Notes: Every user request on a live link is forwarded one cycle later.
`timescale 1ns/1ps
module iocm_owner (
	input wire logic CLK_IN,
	input wire logic RST_IN,
	iocm_link_if.owner lnk,
	input wire logic USER_CONNECT_IN,
	input wire logic USER_INHIBIT_IN,
	input wire logic USER_APP_RUN_IN,
	input wire logic USER_CMD_VALID_IN,
	input wire logic [2:0] USER_CMD_CH_IN,
	input wire logic [15:0] USER_CMD_PCT_IN,
	input wire logic USER_CFG_VALID_IN,
	input wire logic [2:0] USER_CFG_CH_IN,
	input wire logic [2:0] USER_CFG_SEL_IN,
	input wire logic [15:0] USER_CFG_DATA_IN,
	input wire logic [7:0] USER_FLD_LOCKED_IN,
	input wire logic USER_RD_REQ_IN,
	input wire logic [2:0] USER_RD_CH_IN,
	output logic USER_CONNECTED_OUT,
	output iocm_pkg::iocm_mode_t USER_MODE_OUT,
	output logic USER_RD_ACK_OUT,
	output logic [31:0] USER_RD_ENG_OUT,
	output logic [15:0] USER_RD_FDATA_OUT,
	output logic [7:0] USER_RD_FSTAT_OUT,
	output logic USER_RD_FERR_OUT,
	output logic [15:0] USER_RD_AGE_OUT
);
	import iocm_pkg::*;

	// Whole end state in one record
	typedef struct packed {
		logic conn; // Transport connection held
		logic inh, app, cmd_v, cfg_v, rd_v, up, ack, ferr;
		logic [2:0] cmd_ch, cfg_ch, cfg_sel, rd_ch;
		logic [15:0] pct, cfg_d, fdata, age;
		logic [31:0] eng;
		logic [7:0] fstat;
		iocm_mode_t mode;
	} iocm_own_st_t;

	iocm_own_st_t r_reg; // Registered state
	iocm_own_st_t r_next; // Next state

	// Gate application traffic on a live, uninhibited connection
	always_comb begin
		logic live;
		r_next = r_reg;
		// Connection opens only while not inhibited, held across inhibit
		r_next.conn = USER_CONNECT_IN &&
			(r_reg.conn || !USER_INHIBIT_IN);
		live = r_reg.conn && !USER_INHIBIT_IN;
		r_next.up = live;
		r_next.inh = USER_INHIBIT_IN;
		r_next.app = USER_APP_RUN_IN && live;
		r_next.cmd_v = USER_CMD_VALID_IN && live;
		r_next.cmd_ch = USER_CMD_CH_IN;
		r_next.pct = USER_CMD_PCT_IN;
		r_next.cfg_v = USER_CFG_VALID_IN && live;
		r_next.cfg_ch = USER_CFG_CH_IN;
		r_next.cfg_sel = USER_CFG_SEL_IN;
		r_next.cfg_d = USER_CFG_DATA_IN;
		// Field link stays off on channels with unlocked field devices
		if (USER_CFG_SEL_IN == CFG_FLD_EN) begin
			r_next.cfg_d = {15'h0000,
				USER_CFG_DATA_IN[0] & USER_FLD_LOCKED_IN[USER_CFG_CH_IN]};
		end
		r_next.rd_v = USER_RD_REQ_IN && live;
		r_next.rd_ch = USER_RD_CH_IN;
		// Answer pulses dropped while inhibited; answer data is latched regardless
		r_next.ack = lnk.rd_ack && live;
		if (lnk.rd_ack) begin
			r_next.eng = lnk.rd_eng;
			r_next.fdata = lnk.rd_fdata;
			r_next.fstat = lnk.rd_fstat;
			r_next.ferr = lnk.rd_ferr;
			r_next.age = lnk.rd_age;
		end
		r_next.mode = lnk.mode;
	end

	// State register
	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			r_reg <= '0;
			r_reg.mode <= M_OFFLINE;
		end else begin
			r_reg <= r_next;
		end
	end

	// Outputs straight from the state register
	assign lnk.comm = r_reg.conn;
	assign lnk.app_run = r_reg.app;
	assign lnk.inhibit = r_reg.inh;
	assign lnk.cmd_valid = r_reg.cmd_v;
	assign lnk.cmd_ch = r_reg.cmd_ch;
	assign lnk.cmd_pct = r_reg.pct;
	assign lnk.cfg_valid = r_reg.cfg_v;
	assign lnk.cfg_ch = r_reg.cfg_ch;
	assign lnk.cfg_sel = r_reg.cfg_sel;
	assign lnk.cfg_data = r_reg.cfg_d;
	assign lnk.rd_req = r_reg.rd_v;
	assign lnk.rd_ch = r_reg.rd_ch;
	assign USER_CONNECTED_OUT = r_reg.up;
	assign USER_MODE_OUT = r_reg.mode;
	assign USER_RD_ACK_OUT = r_reg.ack;
	assign USER_RD_ENG_OUT = r_reg.eng;
	assign USER_RD_FDATA_OUT = r_reg.fdata;
	assign USER_RD_FSTAT_OUT = r_reg.fstat;
	assign USER_RD_FERR_OUT = r_reg.ferr;
	assign USER_RD_AGE_OUT = r_reg.age;
endmodule // iocm_owner

// ===== tb/iocm_properties.sv
// Purpose: Link properties between the owner end and the I/O module end.
// Assumes: One clock; reset synchronous and active high.
// Notes: Sees link signals only; the bench keeps pin faults clear of them.
`timescale 1ns/1ps
module iocm_properties #(
	parameter int MS_CYCLES = 10, // Cycles per millisecond
	parameter int CMD_TIMEOUT = 4 // Command watchdog in ms
) (
	input wire logic CLK_IN,
	input wire logic RST_IN,
	input wire logic comm,
	input wire logic app_run,
	input wire logic inhibit,
	input wire logic cmd_valid,
	input wire logic rd_req,
	input wire logic rd_ack,
	input wire iocm_pkg::iocm_mode_t mode
);
	import iocm_pkg::*;
	default clocking @(posedge CLK_IN);
	endclocking
	default disable iff (RST_IN);
	// One ms of slack, since the ms tick phase is free running
	localparam int IDLE_MAX = (CMD_TIMEOUT + 1) * MS_CYCLES + 2;
	int idle_reg; // Run cycles without a command
	int idle_next;
	// Count only while running unfed
	always_comb begin
		idle_next = 0;
		if (mode == M_RUN && !cmd_valid) begin
			idle_next = idle_reg + 1;
		end
	end
	always_ff @(posedge CLK_IN) begin
		idle_reg <= RST_IN ? 0 : idle_next;
	end
	inhibit_prog_a: assert property (
		(mode inside {M_READY, M_RECOVER, M_RUN}) && inhibit
		|=> mode == M_PROGRAM) else $error("inhibit gave no program mode");
	uninhibit_sd_a: assert property (
		mode == M_PROGRAM && !inhibit |=> mode == M_SHUTDOWN)
		else $error("uninhibit did not give shutdown");
	lock_exit_a: assert property (
		mode == M_OFFLINE |=> mode inside {M_OFFLINE, M_SHUTDOWN})
		else $error("offline left for a wrong mode");
	sd_ready_a: assert property (
		mode == M_SHUTDOWN && comm && !app_run && !inhibit
		|=> mode == M_READY) else $error("shutdown did not give ready");
	sd_recover_a: assert property (
		mode == M_SHUTDOWN && comm && app_run && !inhibit
		|=> mode == M_RECOVER) else $error("shutdown did not give recover");
	ready_run_a: assert property (
		mode == M_READY && comm && app_run && !inhibit |=> mode == M_RUN)
		else $error("application start did not give run");
	ready_lost_a: assert property (
		mode == M_READY && !comm && !inhibit |=> mode == M_SHUTDOWN)
		else $error("lost link in ready did not give shutdown");
	recover_run_a: assert property (
		mode == M_RECOVER && comm && cmd_valid && !inhibit
		|=> mode == M_RUN) else $error("command in recover gave no run");
	run_fed_a: assert property (
		idle_reg <= IDLE_MAX) else $error("unfed run mode lasted too long");
	rd_answer_a: assert property (
		rd_req && comm |=> rd_ack) else $error("report request unanswered");
endmodule // iocm_properties

// ===== tb/tb_io_channel_mode_sequencer.sv
// Purpose: Self-checking bench joining the owner end and the module end.
// Assumes: Shortened ms, poll and watchdog counts set below.
// Notes: Expected values come from bench functions, not the design.
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin \
	mismatches++; \
	$display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module tb_io_channel_mode_sequencer;
	import iocm_pkg::*;
	localparam int MSC = 32'ha; // Short millisecond
	logic clk, rst = 1'b1, lock = 0, pf = 0, fv = 0, fer = 0, par = 0; // Pins
	logic con = 0, inh = 0, apr = 0, cv = 0, gv = 0, rr = 0; // User
	logic [2:0] fch = 0, cch = 0, gch = 0, gsl = 0, rch = 0;
	logic [7:0] fcm = 0, fst = 0, flk = 0, chon, freq, ufs;
	logic [15:0] fdt = 0, cpc = 0, gdt = 0, ufd, uage;
	logic [31:0] ueng;
	logic ucon, uack, ufe;
	iocm_w16_t meas = '0, cur;
	iocm_w8_t fcmd;
	iocm_led_t hled, rled, uled;
	iocm_leds_t chled;
	iocm_mode_t dmode, umode;
	int mismatches = 0, checked = 0, acks = 0, stray = 0, i, sdv, pgv;
	int seed, lo[8], hi[8], pct[8];
	iocm_link_if link();
	iocm_dev #(.MS_CYCLES(MSC), .POLL_PERIOD_MS(3), .CMD_TIMEOUT(4))
	iocm_dev_i (.CLK_IN(clk), .RST_IN(rst), .lnk(link), .LOCK_IN(lock),
		.POWER_FAULT_IN(pf), .PARTNER_RUN_IN(par), .MEAS_IN(meas),
		.FIELD_RSP_VALID_IN(fv), .FIELD_RSP_CH_IN(fch),
		.FIELD_RSP_CMD_IN(fcm), .FIELD_RSP_DATA_IN(fdt),
		.FIELD_RSP_STAT_IN(fst), .FIELD_RSP_ERR_IN(fer),
		.CH_CURRENT_OUT(cur), .CH_ON_OUT(chon), .FIELD_REQ_OUT(freq),
		.FIELD_CMD_OUT(fcmd), .HEALTHY_LED_OUT(hled),
		.READY_LED_OUT(rled), .RUN_LED_OUT(uled), .CH_LED_OUT(chled),
		.MODE_OUT(dmode));
	iocm_owner iocm_owner_i (.CLK_IN(clk), .RST_IN(rst), .lnk(link),
		.USER_CONNECT_IN(con), .USER_INHIBIT_IN(inh),
		.USER_APP_RUN_IN(apr), .USER_CMD_VALID_IN(cv),
		.USER_CMD_CH_IN(cch), .USER_CMD_PCT_IN(cpc),
		.USER_CFG_VALID_IN(gv), .USER_CFG_CH_IN(gch),
		.USER_CFG_SEL_IN(gsl), .USER_CFG_DATA_IN(gdt),
		.USER_FLD_LOCKED_IN(flk), .USER_RD_REQ_IN(rr),
		.USER_RD_CH_IN(rch), .USER_CONNECTED_OUT(ucon),
		.USER_MODE_OUT(umode), .USER_RD_ACK_OUT(uack),
		.USER_RD_ENG_OUT(ueng),
		.USER_RD_FDATA_OUT(ufd), .USER_RD_FSTAT_OUT(ufs),
		.USER_RD_FERR_OUT(ufe), .USER_RD_AGE_OUT(uage));
	iocm_properties #(.MS_CYCLES(MSC), .CMD_TIMEOUT(4)) iocm_properties_i (
		.CLK_IN(clk), .RST_IN(rst), .comm(link.comm),
		.app_run(link.app_run), .inhibit(link.inhibit),
		.cmd_valid(link.cmd_valid), .rd_req(link.rd_req),
		.rd_ack(link.rd_ack), .mode(link.mode));
	// Free running 25 MHz clock
	initial begin
		clk = 0;
		forever #20 clk = ~clk;
	end
	// Count answers and polls to channels that must stay quiet
	always @(negedge clk) begin
		if (uack === 1'b1) acks++;
		if (!rst && (freq & 8'hdf) !== 8'h00) stray++;
	end
	function automatic int rnd(input int n);
		return int'($unsigned($random(seed)) % n);
	endfunction
	// Percent to clamped microamps, truncated toward zero
	function automatic logic [15:0] scale(input int p, l, h);
		int c;
		c = l + p * (h - l) / ENG_FULL;
		if (c < 0) c = 0;
		if (c > I_MAX) c = I_MAX;
		return c[15:0];
	endfunction
	// Microamps to percent, extrapolated beyond the bounds
	function automatic logic [31:0] eng(input int m, l, h);
		return (m - l) * ENG_FULL / (h - l);
	endfunction
	task automatic give_verdict();
		if (mismatches == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// Bounded wait for a module mode
	task automatic wait_mode(input iocm_mode_t m);
		for (int n = 0; n < 200 && dmode !== m; n++) @(negedge clk);
		`CHK("mode", m, dmode)
	endtask
	task automatic cfg(input logic [2:0] ch, sel, input int d);
		@(posedge clk);
		gv <= 1'b1;
		gch <= ch;
		gsl <= sel;
		gdt <= d[15:0];
		@(posedge clk);
		gv <= 1'b0;
	endtask
	task automatic cmd(input logic [2:0] ch, input int p);
		@(posedge clk);
		cv <= 1'b1;
		cch <= ch;
		cpc <= p[15:0];
		@(posedge clk);
		cv <= 1'b0;
	endtask
	// Report request; e is the number of answers expected
	task automatic rd(input logic [2:0] ch, input int e);
		int n;
		n = acks;
		@(posedge clk);
		rr <= 1'b1;
		rch <= ch;
		@(posedge clk);
		rr <= 1'b0;
		repeat (6) @(negedge clk);
		`CHK("acks", e, acks - n)
	endtask
	// Await a channel 5 poll, then answer it like a field device
	task automatic field(input logic [7:0] c, input logic e);
		for (int n = 0; n < 4 * MSC && freq[5] !== 1'b1; n++) @(negedge clk);
		`CHK("poll", 1'b1, freq[5])
		`CHK("fcmd", c, fcmd[5])
		@(posedge clk);
		fv <= 1'b1;
		fch <= 3'h5;
		fcm <= c;
		fer <= e;
		fdt <= 16'(rnd(32'h10000));
		fst <= 8'(rnd(32'h100));
		@(posedge clk);
		fv <= 1'b0;
	endtask
	initial begin
		seed = 32'hfce5;
		for (i = 0; i < 8; i++) begin
			lo[i] = LO_SIG_RST;
			hi[i] = HI_SIG_RST;
		end
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		`CHK("off mode", M_OFFLINE, dmode)
		`CHK("off on", 8'h00, chon)
		`CHK("off cur", '0, cur)
		`CHK("off led", {LED_GREEN, LED_OFF, LED_RED}, {hled, rled, uled})
		// Connect while inhibited and lock the module in place, all in one cycle
		@(posedge clk);
		inh <= 1'b1;
		con <= 1'b1;
		lock <= 1'b1;
		wait_mode(M_SHUTDOWN);
		repeat (2) @(negedge clk);
		`CHK("sd led", {LED_RED, LED_RED}, {rled, uled})
		`CHK("inh conn", 1'b0, link.comm)
		@(posedge clk);
		pf <= 1'b1;
		repeat (6) @(negedge clk);
		`CHK("fault led", LED_RED, hled)
		`CHK("fault mode", M_SHUTDOWN, dmode)
		@(posedge clk);
		pf <= 1'b0;
		// Fault must leave the synchroniser before the link comes up
		repeat (4) @(posedge clk);
		inh <= 1'b0;
		wait_mode(M_READY);
		repeat (2) @(negedge clk);
		`CHK("rdy led", {LED_GREEN, LED_GREEN, LED_RED}, {hled, rled, uled})
		`CHK("rdy on", 8'h00, chon)
		@(posedge clk);
		con <= 1'b0;
		wait_mode(M_SHUTDOWN);
		@(posedge clk);
		con <= 1'b1;
		flk <= 8'h20;
		wait_mode(M_READY);
		sdv = rnd(I_MAX + 1);
		pgv = rnd(I_MAX + 1);
		lo[7] = rnd(LO_SIG_RST * 2);
		hi[7] = lo[7] + 16'h03e8 + rnd(16'h3a98);
		cfg(0, CFG_SD_SEL, SEL_VALUE);
		cfg(0, CFG_SD_VAL, sdv);
		cfg(1, CFG_SD_SEL, SEL_HOLD);
		cfg(3, CFG_PG_SEL, SEL_VALUE);
		cfg(3, CFG_PG_VAL, pgv);
		cfg(7, CFG_LO_SIG, lo[7]);
		cfg(7, CFG_HI_SIG, hi[7]);
		cfg(5, CFG_FLD_EN, 1);
		cfg(6, CFG_FLD_EN, 1);
		@(posedge clk);
		for (i = 0; i < 8; i++)
			meas[i] <= (i == 0) ? 16'h0bb8 : 16'(rnd(I_MAX + 1));
		for (i = 0; i < 8; i++) begin
			rd(i[2:0], 1);
			`CHK("eng", eng(meas[i], lo[i], hi[i]), ueng)
		end
		field(CMD_READ_ID, 1'b0);
		field(CMD_READ_DYN, 1'b1);
		rd(3'h5, 1);
		`CHK("ferr", 1'b1, ufe)
		field(CMD_READ_DYN, 1'b0);
		rd(3'h5, 1);
		`CHK("fdata", fdt, ufd)
		`CHK("fstat", fst, ufs)
		`CHK("ferr", 1'b0, ufe)
		`CHK("age", 1'b1, uage <= 1)
		@(posedge clk);
		apr <= 1'b1;
		wait_mode(M_RUN);
		// Random percentages, with one far high and one far low corner
		for (i = 0; i < 8; i++) begin
			pct[i] = rnd(2 * ENG_FULL) - ENG_FULL / 4;
			if (i == 6) pct[i] = 2 * ENG_FULL;
			if (i == 4) pct[i] = -ENG_FULL;
			cmd(i[2:0], pct[i]);
		end
		repeat (3) @(negedge clk);
		for (i = 0; i < 8; i++)
			`CHK("cur", scale(pct[i], lo[i], hi[i]), cur[i])
		`CHK("run on", 8'hff, chon)
		`CHK("run led", {3{LED_GREEN}}, {rled, uled, chled[0]})
		`CHK("user mode", M_RUN, umode)
		// Partner running: this end carries half, then all again
		@(posedge clk);
		par <= 1'b1;
		repeat (4) @(negedge clk);
		`CHK("duplex", scale(pct[5], lo[5], hi[5]) >> 1, cur[5])
		@(posedge clk);
		par <= 1'b0;
		// Commands stop: shutdown, then recover since the app runs
		wait_mode(M_RECOVER);
		repeat (3) @(negedge clk);
		`CHK("sd val", sdv[15:0], cur[0])
		`CHK("sd hold", scale(pct[1], lo[1], hi[1]), cur[1])
		`CHK("sd off", 19'h00003, {cur[2], chon[2:0]})
		cmd(3'h2, pct[2]);
		wait_mode(M_RUN);
		@(posedge clk);
		inh <= 1'b1;
		wait_mode(M_PROGRAM);
		repeat (3) @(negedge clk);
		`CHK("pg val", {pgv[15:0], 16'h0000}, {cur[3], cur[0]})
		`CHK("pg conn", 1'b0, ucon)
		rd(3'h0, 0);
		@(posedge clk);
		inh <= 1'b0;
		wait_mode(M_RECOVER);
		`CHK("stray polls", 0, stray)
		give_verdict();
	end
	// Hang guard, well beyond the expected run length
	initial begin
		repeat (32'h4e20) @(posedge clk);
		mismatches++;
		give_verdict();
	end
endmodule // tb_io_channel_mode_sequencer
